// ==== hw/spfc_pkg.sv ====
// package for the switch protection and fault control block
// assumes a single 20 MHz clock and an APB register slave
package spfc_pkg;
  localparam int          NUM_CH           = 4;
  localparam int          CLK_HZ           = 20_000_000;
  // retry interval in microseconds and derived count
  localparam int          RETRY_US         = 1000;
  localparam int          RETRY_CYC        = RETRY_US * (CLK_HZ / 1_000_000);
  // reverse recheck interval in microseconds and derived count
  localparam int          RECHECK_US       = 100;
  localparam int          RECHECK_CYC      = RECHECK_US * (CLK_HZ / 1_000_000);
  // configuration load time after both supplies are good
  localparam int          CFG_LOAD_CYC     = 16;
  localparam int          CNT_W            = 24;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL         = 12'h000;
  localparam logic [11:0] OFS_SWITCH       = 12'h004;
  localparam logic [11:0] OFS_RCB          = 12'h008;
  localparam logic [11:0] OFS_STATUS       = 12'h00C;
  localparam logic [11:0] OFS_THERM        = 12'h010;
  localparam logic [11:0] OFS_ADC          = 12'h014;
  // control register fields
  localparam int          CTRL_LATCH_BIT   = 0;
  localparam int          CTRL_UVMASK_BIT  = 1;
  localparam int          CTRL_RCBDIS_BIT  = 2;
  localparam int          CTRL_PORCLR_BIT  = 3;
  // status register fields
  localparam int          ST_POR_BIT       = 0;
  localparam int          ST_LOADUV_BIT    = 1;
  localparam int          ST_LOGICUV_BIT   = 2;
  localparam int          ST_READY_BIT     = 3;
  localparam int          ST_RVRS_LSB      = 4;
  localparam int          ST_SNSOFF_LSB    = 8;
  localparam logic [3:0]  RCB_EN_RST       = 4'h0;
  localparam logic [3:0]  SWITCH_RST       = 4'h0;
  localparam int          ADC_W            = 12;
  typedef enum logic [1:0] {SPFC_OFF, SPFC_LOAD, SPFC_RUN} spfc_pwr_t;
endpackage : spfc_pkg

// ==== hw/spfc_top.sv ====
// protection and fault control for a four channel high-side switch
// assumes comparator and sensor inputs synchronous to clock
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module spfc_top
  import spfc_pkg::*;
#(
  parameter int RETRY_CYCLES   = RETRY_CYC,
  parameter int RECHECK_CYCLES = RECHECK_CYC
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // supply comparators
  input  wire logic                loadSupplyLowFalling,
  input  wire logic                loadSupplyLowRising,
  input  wire logic                logicSupplyLowFalling,
  input  wire logic                logicSupplyLowRising,
  // per-channel thermal comparators
  input  wire logic [NUM_CH-1:0]   absoluteTempLimit,
  input  wire logic [NUM_CH-1:0]   relativeTempLimit,
  input  wire logic [NUM_CH-1:0]   tempHysteresisOk,
  // per-channel reverse comparators
  input  wire logic [NUM_CH-1:0]   reverseRisingThreshold,
  input  wire logic [NUM_CH-1:0]   reverseFallingThreshold,
  // output enable pin and adc sample
  input  wire logic                outputEnable,
  input  wire logic [ADC_W-1:0]    adcSample,
  input  wire logic [1:0]          adcChannel,
  // output pins; channel, fault and ready pins each with enable
  output logic [NUM_CH-1:0]        channelOn,
  output logic                     channelOe,
  output logic [NUM_CH-1:0]        blockGateOn,
  output logic                     faultPin_n,
  output logic                     faultPinOe,
  output logic                     readyPin_n,
  output logic                     readyPinOe,
  output logic                     senseEnable
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    spfc_pwr_t                 pwr;
    logic [CNT_W-1:0]          loadCnt;
    logic                      latchCfg;
    logic                      uvMask;
    logic                      rcbDisable;
    logic [NUM_CH-1:0]         switchState;
    logic [NUM_CH-1:0]         rcbEnable;
    logic                      porFlag;
    logic                      loadUv;
    logic                      logicUv;
    logic [NUM_CH-1:0]         absFault;
    logic [NUM_CH-1:0]         relFault;
    logic [NUM_CH-1:0]         tsdLatched;
    logic [NUM_CH-1:0]         rvrsFlag;
    logic [NUM_CH-1:0]         rvrsHold;
    logic [NUM_CH*CNT_W-1:0]   retryCnt;
    logic [NUM_CH*CNT_W-1:0]   recheckCnt;
    logic [NUM_CH-1:0]         chOn;
    logic [NUM_CH-1:0]         gateOn;
    logic                      fltN;
    logic                      pinOe;
    logic                      rdyN;
    logic                      snsEn;
    logic                      ready;
    logic [31:0]               rdata;
    logic [ADC_W-1:0]          adcReg;
  } spfc_state_t;

  spfc_state_t st_r;
  spfc_state_t st_nxt;

  logic wrStrobe;
  logic rdStrobe;
  logic suppliesOk;
  logic anyRvrs;

  // read data launched from the setup cycle so it stands with pready
  assign wrStrobe   = psel && penable && pwrite && pready;
  assign rdStrobe   = psel && !penable && !pwrite;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [CNT_W-1:0] rc;
    logic [CNT_W-1:0] kc;
    logic             normalRcb;
    st_nxt     = st_r;
    rc         = '0;
    kc         = '0;
    normalRcb  = 1'b0;
    // supply monitors with hysteresis
    if (loadSupplyLowFalling) begin
      st_nxt.loadUv = 1'b1;
    end else if (!loadSupplyLowRising) begin
      st_nxt.loadUv = 1'b0;
    end
    if (logicSupplyLowFalling) begin
      st_nxt.logicUv = 1'b1;
    end else if (!logicSupplyLowRising) begin
      st_nxt.logicUv = 1'b0;
    end
    suppliesOk = !st_nxt.loadUv && !st_nxt.logicUv;
    // power sequencing
    unique case (st_r.pwr)
      SPFC_OFF: begin
        st_nxt.loadCnt = '0;
        if (suppliesOk) begin
          st_nxt.pwr = SPFC_LOAD;
        end
      end
      SPFC_LOAD: begin
        st_nxt.loadCnt = st_r.loadCnt + CNT_W'(1);
        if (st_nxt.logicUv) begin
          st_nxt.pwr = SPFC_OFF;
        end else if (st_r.loadCnt == CNT_W'(CFG_LOAD_CYC - 1)) begin
          st_nxt.pwr = SPFC_RUN;
        end
      end
      SPFC_RUN: begin
        if (st_nxt.logicUv) begin
          st_nxt.pwr = SPFC_OFF;
        end
      end
      default: begin
        st_nxt.pwr = SPFC_OFF;
      end
    endcase
    st_nxt.ready = (st_nxt.pwr == SPFC_RUN);
    // per-channel thermal and reverse blocking
    for (int ch = 0; ch < NUM_CH; ch++) begin
      rc = st_r.retryCnt[ch*CNT_W +: CNT_W];
      kc = st_r.recheckCnt[ch*CNT_W +: CNT_W];
      if (absoluteTempLimit[ch]) begin
        st_nxt.absFault[ch] = 1'b1;
      end else if (tempHysteresisOk[ch]) begin
        st_nxt.absFault[ch] = 1'b0;
      end
      // retry timer reloads while the relative limit holds
      if (relativeTempLimit[ch]) begin
        st_nxt.relFault[ch] = 1'b1;
        rc = CNT_W'(RETRY_CYCLES);
      end else if (rc != '0) begin
        rc = rc - CNT_W'(1);
        if (rc == '0) begin
          st_nxt.relFault[ch] = 1'b0;
        end
      end
      if (st_nxt.absFault[ch] || st_nxt.relFault[ch]) begin
        if (st_r.latchCfg) begin
          st_nxt.tsdLatched[ch] = 1'b1;
        end
      end
      st_nxt.retryCnt[ch*CNT_W +: CNT_W] = rc;
      normalRcb = !st_r.rcbDisable && st_r.rcbEnable[ch];
      if (!normalRcb) begin
        st_nxt.rvrsHold[ch] = 1'b0;
        st_nxt.rvrsFlag[ch] = 1'b0;
        kc = '0;
      end else if (st_r.rvrsHold[ch]) begin
        if (kc != '0) begin
          kc = kc - CNT_W'(1);
          // falling comparator still high: restart the hold
          if (reverseFallingThreshold[ch]) begin
            kc = CNT_W'(RECHECK_CYCLES);
          end
        end else begin
          st_nxt.rvrsHold[ch] = 1'b0;
        end
      end else if (reverseRisingThreshold[ch] && st_r.gateOn[ch]) begin
        st_nxt.rvrsHold[ch] = 1'b1;
        st_nxt.rvrsFlag[ch] = 1'b1;
        kc = CNT_W'(RECHECK_CYCLES);
      end
      st_nxt.recheckCnt[ch*CNT_W +: CNT_W] = kc;
      // main switch; writes are kept while outputEnable is low
      st_nxt.chOn[ch] = st_nxt.ready && !st_nxt.loadUv && outputEnable
                        && st_r.switchState[ch]
                        && !st_nxt.absFault[ch] && !st_nxt.relFault[ch]
                        && !st_nxt.tsdLatched[ch];
      st_nxt.gateOn[ch] = st_nxt.ready && !st_nxt.loadUv && normalRcb
                          && st_r.switchState[ch] && outputEnable
                          && !st_nxt.rvrsHold[ch];
    end
    anyRvrs = |st_nxt.rvrsHold;
    // register bus
    st_nxt.rdata = '0;
    if (wrStrobe && st_r.ready) begin
      unique case (paddr)
        OFS_CTRL: begin
          st_nxt.latchCfg   = pwdata[CTRL_LATCH_BIT];
          st_nxt.uvMask     = pwdata[CTRL_UVMASK_BIT];
          st_nxt.rcbDisable = pwdata[CTRL_RCBDIS_BIT];
          if (pwdata[CTRL_PORCLR_BIT]) begin
            st_nxt.porFlag = 1'b0;
          end
        end
        OFS_SWITCH: begin
          st_nxt.switchState = pwdata[NUM_CH-1:0];
          for (int ch = 0; ch < NUM_CH; ch++) begin
            // a clear never beats a fault in the same cycle
            if (!pwdata[ch] && !st_nxt.absFault[ch] && !st_nxt.relFault[ch]) begin
              st_nxt.tsdLatched[ch] = 1'b0;
            end
          end
        end
        OFS_RCB: begin
          st_nxt.rcbEnable = pwdata[NUM_CH-1:0];
        end
        OFS_STATUS: begin
          // set wins: a channel still holding keeps its flag
          for (int ch = 0; ch < NUM_CH; ch++) begin
            if (pwdata[ST_RVRS_LSB + ch] && !st_nxt.rvrsHold[ch]) begin
              st_nxt.rvrsFlag[ch] = 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (rdStrobe) begin
      unique case (paddr)
        OFS_CTRL: begin
          st_nxt.rdata[CTRL_LATCH_BIT]  = st_r.latchCfg;
          st_nxt.rdata[CTRL_UVMASK_BIT] = st_r.uvMask;
          st_nxt.rdata[CTRL_RCBDIS_BIT] = st_r.rcbDisable;
        end
        OFS_SWITCH: begin
          st_nxt.rdata[NUM_CH-1:0] = st_r.switchState;
        end
        OFS_RCB: begin
          st_nxt.rdata[NUM_CH-1:0] = st_r.rcbEnable;
        end
        OFS_STATUS: begin
          st_nxt.rdata[ST_POR_BIT]              = st_r.porFlag;
          st_nxt.rdata[ST_LOADUV_BIT]           = st_r.loadUv;
          st_nxt.rdata[ST_LOGICUV_BIT]          = st_r.logicUv;
          st_nxt.rdata[ST_READY_BIT]            = st_r.ready;
          st_nxt.rdata[ST_RVRS_LSB +: NUM_CH]   = st_r.rvrsFlag;
          st_nxt.rdata[ST_SNSOFF_LSB +: NUM_CH] = st_r.rvrsHold;
        end
        OFS_THERM: begin
          st_nxt.rdata[NUM_CH-1:0]         = st_r.absFault;
          st_nxt.rdata[NUM_CH +: NUM_CH]   = st_r.relFault;
          st_nxt.rdata[2*NUM_CH +: NUM_CH] = st_r.tsdLatched;
        end
        OFS_ADC: begin
          st_nxt.rdata[ADC_W-1:0] = st_r.adcReg;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
    // sense and adc forced to zero during a reverse event
    st_nxt.snsEn  = st_nxt.ready && !anyRvrs;
    st_nxt.adcReg = anyRvrs ? '0 : adcSample;
    if (st_nxt.rvrsHold[adcChannel]) begin
      st_nxt.adcReg = '0;
    end
    // pins
    st_nxt.pinOe = st_nxt.pwr != SPFC_OFF || !st_nxt.logicUv;
    st_nxt.rdyN  = !st_nxt.ready;
    st_nxt.fltN  = !((st_nxt.loadUv && !st_r.uvMask)
                     || (|st_nxt.rvrsFlag)
                     || (|st_nxt.absFault) || (|st_nxt.relFault));
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r             <= '0;
      st_r.pwr         <= SPFC_OFF;
      st_r.switchState <= SWITCH_RST;
      st_r.rcbEnable   <= RCB_EN_RST;
      st_r.porFlag     <= 1'b1;
      // supplies read low until the comparators say otherwise
      st_r.loadUv      <= 1'b1;
      st_r.logicUv     <= 1'b1;
      st_r.fltN        <= 1'b1;
      st_r.rdyN        <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // zero wait states: pready stands in the access cycle
      pready  <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  assign prdata      = st_r.rdata;
  assign channelOn   = st_r.chOn;
  assign channelOe   = st_r.pinOe;
  assign blockGateOn = st_r.gateOn;
  assign faultPin_n  = st_r.fltN;
  assign faultPinOe  = st_r.pinOe;
  assign readyPin_n  = st_r.rdyN;
  assign readyPinOe  = st_r.pinOe;
  assign senseEnable = st_r.snsEn;

endmodule : spfc_top

// ==== bench/spfc_chk.sv ====
// checker: protection relations seen at the top ports
// assumes one clock domain with active high reset
`timescale 1ns/1ns
module spfc_chk
  import spfc_pkg::*;
(
  // clock and reset
  input wire logic              clock,
  input wire logic              reset,
  // comparators and enable pin
  input wire logic              loadSupplyLowFalling,
  input wire logic              logicSupplyLowFalling,
  input wire logic [NUM_CH-1:0] absoluteTempLimit,
  input wire logic [NUM_CH-1:0] relativeTempLimit,
  input wire logic [NUM_CH-1:0] reverseRisingThreshold,
  input wire logic              outputEnable,
  // outputs
  input wire logic [NUM_CH-1:0] channelOn,
  input wire logic              channelOe,
  input wire logic [NUM_CH-1:0] blockGateOn,
  input wire logic              faultPin_n,
  input wire logic              faultPinOe,
  input wire logic              readyPin_n,
  input wire logic              readyPinOe,
  input wire logic              senseEnable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic [NUM_CH-1:0] hot;
  logic [NUM_CH-1:0] trip;
  assign hot = absoluteTempLimit | relativeTempLimit;
  assign trip = reverseRisingThreshold & blockGateOn;
  AST_RESET_HIZ: assert property (disable iff (1'b0)
    reset |-> !channelOe && !faultPinOe && !readyPinOe) else $error("pin driven in reset");
  AST_THERM_OFF: assert property (|hot |=> (channelOn & $past(hot)) == '0)
    else $error("hot channel left on");
  AST_LOAD_UV: assert property (loadSupplyLowFalling |=> channelOn == '0)
    else $error("channel on in load undervoltage");
  AST_LOGIC_UV: assert property (logicSupplyLowFalling |=> readyPin_n && channelOn == '0)
    else $error("logic undervoltage not handled");
  AST_NOT_READY: assert property (readyPin_n [*2] |-> channelOn == '0)
    else $error("channel on before ready");
  AST_REV_TRIP: assert property (|trip |=> !faultPin_n && (blockGateOn & $past(trip)) == '0)
    else $error("reverse trip not handled");
  AST_REV_SENSE: assert property (|trip |=> !senseEnable)
    else $error("sense left on in reverse");
  AST_OE_LOW: assert property (!outputEnable |=> channelOn == '0)
    else $error("channel on with enable low");
  cover property (|hot);
  cover property (|trip);
  cover property (logicSupplyLowFalling);
endmodule : spfc_chk
bind spfc_top spfc_chk i_chk (.clock, .reset, .loadSupplyLowFalling, .logicSupplyLowFalling,
  .absoluteTempLimit, .relativeTempLimit, .reverseRisingThreshold, .outputEnable, .channelOn,
  .channelOe, .blockGateOn, .faultPin_n, .faultPinOe, .readyPin_n, .readyPinOe, .senseEnable);

// ==== bench/spfc_host.sv ====
// host model: apb master and pulled-up fault and ready lines
// assumes tasks are entered right after a rising edge
`timescale 1ns/1ns
module spfc_host (
  // apb master
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  // pins and their line levels
  input  wire logic        faultPin_n,
  input  wire logic        faultPinOe,
  input  wire logic        readyPin_n,
  input  wire logic        readyPinOe,
  output logic             faultLine,
  output logic             readyLine
);
  assign faultLine = faultPinOe ? faultPin_n : 1'b1;
  assign readyLine = readyPinOe ? readyPin_n : 1'b1;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not look held
    pwdata <= ~d;
    @(posedge clock);
  endtask : xfer
endmodule : spfc_host

// ==== bench/test_switch_protection_fault_control.sv ====
// bench: drives comparators and apb, checks pins and read data
// assumes shortened retry and recheck intervals
`timescale 1ns/1ns
module test_switch_protection_fault_control;
  import spfc_pkg::*;
  localparam int RT = 20;
  localparam int RC = 10;
  logic clock, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic loadFall, loadRise, logicFall, logicRise, outputEnable, senseEnable;
  logic [3:0] abs, rel, hyst, revRise, revFall, channelOn, blockGateOn;
  logic [11:0] adcSample;
  logic [1:0] adcChannel;
  logic channelOe, faultPin_n, faultPinOe, readyPin_n, readyPinOe, faultLine, readyLine;
  logic [63:0] q[$];
  logic [63:0] note;
  integer seed = 32'h33c2823d;
  int error_cnt = 0;
  int compares = 0;
  spfc_top #(.RETRY_CYCLES(RT), .RECHECK_CYCLES(RC)) i_dut (.clock, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .loadSupplyLowFalling(loadFall),
    .loadSupplyLowRising(loadRise), .logicSupplyLowFalling(logicFall),
    .logicSupplyLowRising(logicRise), .absoluteTempLimit(abs), .relativeTempLimit(rel),
    .tempHysteresisOk(hyst), .reverseRisingThreshold(revRise),
    .reverseFallingThreshold(revFall), .outputEnable, .adcSample, .adcChannel, .channelOn,
    .channelOe, .blockGateOn, .faultPin_n, .faultPinOe, .readyPin_n, .readyPinOe, .senseEnable);
  spfc_host i_host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .faultPin_n,
    .faultPinOe, .readyPin_n, .readyPinOe, .faultLine, .readyLine);
  initial clock = 1'b0;
  always #25 clock = ~clock;
  always @(posedge clock) adcSample <= 12'($random(seed));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task w(input int n);
    repeat (n) @(posedge clock);
  endtask : w
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back({m, e});
    i_host.xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  task wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d);
  endtask : wr
  task waitReady;
    for (int i = 0; i < 60 && readyLine !== 1'b0; i++) @(posedge clock);
    chk(32'(readyLine), 32'h0000_0000, "ready not low");
  endtask : waitReady
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // read result monitor
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      note = (q.size() > 0) ? q.pop_front() : 64'hFFFF_FFFF_FFFF_FFFF;
      chk(prdata & note[63:32], note[31:0], "read data");
      chk(32'(pslverr), 32'h0000_0000, "slave error");
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, loadFall, loadRise, logicFall, logicRise, outputEnable} = 6'h3F;
    {abs, rel, hyst, revRise, revFall} = 20'h0_0000;
    adcChannel = 2'h0;
    w(3);
    chk(32'(channelOe | faultPinOe | readyPinOe), 32'h0000_0000, "pins driven");
    w(2);
    reset <= 1'b0;
    logicFall <= 1'b0;
    logicRise <= 1'b0;
    w(30);
    chk(32'(readyLine), 32'h0000_0001, "ready early");
    chk(32'(channelOn), 32'h0000_0000, "outputs early");
    rd(OFS_STATUS, 32'h0000_0003, 32'h0000_0003);
    loadFall <= 1'b0;
    loadRise <= 1'b0;
    waitReady();
    rd(OFS_STATUS, 32'h0000_0008, 32'h0000_000E);
    wr(OFS_SWITCH, 32'h0000_0007);
    wr(OFS_RCB, 32'h0000_0007);
    w(3);
    chk(32'(blockGateOn), 32'h0000_0007, "gate drive");
    $display("test power up done");
    abs <= 4'h1;
    w(2);
    abs <= 4'h0;
    w(2);
    chk(32'(channelOn), 32'h0000_0006, "abs shutdown");
    chk(32'(faultLine), 32'h0000_0000, "thermal fault pin");
    w(10);
    chk(32'(channelOn), 32'h0000_0006, "abs hold");
    hyst <= 4'h1;
    w(3);
    hyst <= 4'h0;
    chk(32'(channelOn), 32'h0000_0007, "abs clear");
    rel <= 4'h2;
    w(2);
    rel <= 4'h0;
    w(RT / 2);
    chk(32'(channelOn), 32'h0000_0005, "rel hold");
    w(RT);
    chk(32'(channelOn), 32'h0000_0007, "rel retry");
    wr(OFS_CTRL, 32'h0000_0001);
    abs <= 4'h1;
    w(2);
    abs <= 4'h0;
    hyst <= 4'h1;
    w(3);
    hyst <= 4'h0;
    chk(32'(channelOn), 32'h0000_0006, "latched off");
    wr(OFS_SWITCH, 32'h0000_0006);
    wr(OFS_SWITCH, 32'h0000_0007);
    wr(OFS_CTRL, 32'h0000_0000);
    chk(32'(channelOn), 32'h0000_0007, "latch released");
    $display("test thermal done");
    loadFall <= 1'b1;
    loadRise <= 1'b1;
    w(3);
    chk(32'(channelOn), 32'h0000_0000, "load uv off");
    chk(32'(faultLine), 32'h0000_0000, "load uv pin");
    rd(OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0002);
    w(2);
    chk(32'(faultLine), 32'h0000_0001, "load uv masked");
    loadFall <= 1'b0;
    w(3);
    chk(32'(channelOn), 32'h0000_0000, "load uv hysteresis");
    loadRise <= 1'b0;
    w(3);
    chk(32'(channelOn), 32'h0000_0007, "load uv recover");
    wr(OFS_CTRL, 32'h0000_0000);
    $display("test load supply done");
    revRise <= 4'h4;
    revFall <= 4'h4;
    adcChannel <= 2'h2;
    w(3);
    chk(32'(blockGateOn), 32'h0000_0003, "reverse trip");
    chk(32'(faultLine), 32'h0000_0000, "reverse pin");
    chk(32'(senseEnable), 32'h0000_0000, "sense off");
    rd(OFS_ADC, 32'h0000_0000, 32'h0000_0FFF);
    rd(OFS_STATUS, 32'h0000_0040, 32'h0000_0040);
    revRise <= 4'h0;
    w(RC + 5);
    chk(32'(blockGateOn), 32'h0000_0003, "reverse hold");
    revFall <= 4'h0;
    w(RC + 5);
    chk(32'(blockGateOn), 32'h0000_0007, "recheck on");
    wr(OFS_STATUS, 32'h0000_0040);
    w(2);
    chk(32'(faultLine), 32'h0000_0001, "reverse flag cleared");
    wr(OFS_CTRL, 32'h0000_000C);
    w(2);
    chk(32'(blockGateOn), 32'h0000_0000, "global disable");
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0000);
    w(2);
    chk(32'(blockGateOn), 32'h0000_0007, "global enable");
    $display("test reverse done");
    outputEnable <= 1'b0;
    w(3);
    chk(32'(channelOn), 32'h0000_0000, "enable low");
    wr(OFS_SWITCH, 32'h0000_0001);
    outputEnable <= 1'b1;
    w(3);
    chk(32'(channelOn), 32'h0000_0001, "stored write");
    logicFall <= 1'b1;
    logicRise <= 1'b1;
    w(3);
    chk(32'(channelOn), 32'h0000_0000, "logic uv off");
    chk(32'(readyLine), 32'h0000_0001, "logic uv ready");
    logicFall <= 1'b0;
    logicRise <= 1'b0;
    waitReady();
    $display("test pins and logic supply done");
    tally_and_finish();
  end
endmodule : test_switch_protection_fault_control
